//--- common/psd_pkg.sv
/*
 * psd_pkg: constants for the paged special register address decoder.
 * assumes an 8-bit direct address space with the special range in its upper half.
 */
package psd_pkg;
    localparam logic [7:0] PSD_SPACE_BASE   = 8'h80;
    localparam logic [7:0] PSD_SPACE_LAST   = 8'hff;
    localparam logic [2:0] PSD_BIT_LOW_MASK = 3'h7;
    localparam logic [2:0] PSD_BIT_LOW_HIT  = 3'h0;
    localparam logic [7:0] PSD_PAGE_SEL_ADR = 8'hbf;
    localparam logic [7:0] PSD_PAGE_RESET   = 8'h00;
    localparam logic [7:0] PSD_PAGE_0       = 8'h00;
    localparam logic [7:0] PSD_PAGE_F       = 8'h0f;
    localparam int         PSD_PAGE_COUNT   = 256;
    localparam logic [7:0] PSD_BIT_BASE     = 8'h80;
    localparam logic [7:0] PSD_UNDEF_READ   = 8'h00;
    typedef enum logic [2:0] {
        PSD_CLS_NONE   = 3'b001,
        PSD_CLS_COMMON = 3'b010,
        PSD_CLS_PAGED  = 3'b100
    } psd_class_t;
endpackage : psd_pkg

//--- dv/psd_core_model.sv
/*
 * psd_core_model: behavioural processor core issuing data accesses.
 * assumes its tasks are entered at a falling edge of i_clock.
 */
`timescale 1ns/1ps
`default_nettype none
module psd_core_model (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    output var  logic       o_req,
    output var  logic       o_direct,
    output var  logic       o_write,
    output var  logic       o_bit_op,
    output var  logic [7:0] o_addr,
    output var  logic [7:0] o_wdata
);
    // quiet bus from time zero
    initial begin
        o_req    = 1'b0;
        o_direct = 1'b0;
        o_write  = 1'b0;
        o_bit_op = 1'b0;
        o_addr   = 8'h00;
        o_wdata  = 8'h00;
    end
    // strobe left high so calls may run back to back; reserved slots only on command
    task automatic access(input logic dir, input logic wr, input logic bop,
                          input logic [7:0] adr, input logic [7:0] dat);
        o_req    = 1'b1;
        o_direct = dir;
        o_write  = wr;
        o_bit_op = bop;
        o_addr   = adr;
        o_wdata  = dat;
        @(negedge i_clock);
    endtask
    // address and data lines inverted so stale values never pass for live ones
    task automatic idle();
        o_req   = 1'b0;
        o_addr  = ~o_addr;
        o_wdata = ~o_wdata;
        @(negedge i_clock);
    endtask
    // interrupt routine: save page, select 0x0f, touch a paged slot, restore
    task automatic isr_touch();
        logic [7:0] saved;
        access(1'b1, 1'b0, 1'b0, 8'hbf, 8'h00);
        saved = i_rdata;
        access(1'b1, 1'b1, 1'b0, 8'hbf, 8'h0f);
        access(1'b1, 1'b0, 1'b0, 8'hc8, 8'h00);
        access(1'b1, 1'b1, 1'b0, 8'hbf, saved);
    endtask
endmodule // psd_core_model
`default_nettype wire

//--- dv/testbench.sv
/*
 * testbench: self-checking bench for psd_decoder driven by the core model.
 * assumes latency one; results sampled at the falling edge after the request.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic req, dir, wr, bop, special_register, ram, res, berr, pgd, we, rv;
    logic [7:0] adr, wd, oadr, page, rdat;
    int num_errors = 0;
    int num_checks = 0;
    wire logic [7:0] flg = {1'b0, special_register, ram, res, berr, pgd, we, rv};

    always #25 i_clock = ~i_clock;

    psd_core_model core_u (.i_clock(i_clock), .i_rdata(rdat), .o_req(req), .o_direct(dir),
        .o_write(wr), .o_bit_op(bop), .o_addr(adr), .o_wdata(wd));
    psd_decoder dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_req(req), .i_direct(dir),
        .i_write(wr), .i_bit_op(bop), .i_addr(adr), .i_wdata(wd), .o_sfr_sel(special_register),
        .o_ram_sel(ram), .o_reserved(res), .o_bit_err(berr), .o_paged(pgd), .o_we(we),
        .o_addr(oadr), .o_page(page), .o_rdata(rdat), .o_rvalid(rv));

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] a);
        core_u.access(1'b1, 1'b0, 1'b0, a, 8'h00);
    endtask
    task automatic wt(input logic [7:0] a, input logic [7:0] d);
        core_u.access(1'b1, 1'b1, 1'b0, a, d);
    endtask
    // flag byte: sfr ram reserved bit_err paged we rvalid
    task automatic t_route();
        rd(8'h7f); chk(flg, 8'h21);
        rd(8'h80); chk(flg, 8'h41);
        core_u.access(1'b0, 1'b0, 1'b0, 8'hff, 8'h00); chk(flg, 8'h21);
        rd(8'hff); chk(flg, 8'h41);
    endtask
    task automatic t_bits();
        core_u.access(1'b1, 1'b1, 1'b1, 8'h8a, 8'h01); chk(flg, 8'h42);
        chk(oadr, 8'h88);
        wt(8'h81, 8'h3c); chk(flg, 8'h42);
        core_u.idle(); chk(flg, 8'h40);
        chk(oadr, 8'h81);
    endtask
    task automatic t_pages();
        wt(8'hbf, 8'h0f); chk(page, 8'h0f);
        rd(8'hc8); chk(flg, 8'h45);
        rd(8'h88); chk(flg, 8'h41);
        wt(8'hbf, 8'h05); rd(8'h88); chk(flg, 8'h51);
        chk(rdat, 8'h00);
        wt(8'h88, 8'h11); chk(flg, 8'h50);
        rd(8'hbf); chk(rdat, 8'h05);
        chk(flg, 8'h41);
        wt(8'hbf, 8'h00); wt(8'h96, 8'h22); chk(flg, 8'h50);
        rd(8'hc8); chk(flg, 8'h45);
        chk(page, 8'h00);
    endtask
    task automatic t_isr();
        wt(8'hbf, 8'ha5); core_u.isr_touch(); chk(page, 8'ha5);
        core_u.idle(); chk(flg, 8'h40);
    endtask
    // mid-run reset with a nonzero page; first read follows at once
    task automatic t_reset();
        i_rst = 1'b1;
        core_u.idle();
        core_u.idle();
        i_rst = 1'b0;
        chk(page, 8'h00);
        chk(flg, 8'h00);
        rd(8'hbf); chk(rdat, 8'h00);
        chk(flg, 8'h41);
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (2000) @(posedge i_clock);
        num_errors++;
        stop_test();
    end
    // reset, then scenarios
    initial begin
        repeat (5) @(negedge i_clock);
        i_rst = 1'b0;
        chk(page, 8'h00);
        chk(flg, 8'h00);
        t_route();
        t_bits();
        t_pages();
        t_isr();
        t_reset();
        stop_test();
    end
endmodule // testbench
`default_nettype wire

//--- verilog/psd_decoder.sv
/*
 * psd_decoder: routes direct-address core accesses to the special register
 * space, holds the page select register and classifies each access.
 * assumes the core presents at most one access per cycle; a strobe held high is one access each cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module psd_decoder
    import psd_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_req,
    input  wire logic       i_direct,
    input  wire logic       i_write,
    input  wire logic       i_bit_op,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic            o_sfr_sel,
    output logic            o_ram_sel,
    output logic            o_reserved,
    output logic            o_bit_err,
    output logic            o_paged,
    output logic            o_we,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_page,
    output logic [7:0]      o_rdata,
    output logic            o_rvalid
);
    typedef struct packed {
        logic [7:0] page;
        logic       sfr_sel;
        logic       ram_sel;
        logic       reserved;
        logic       bit_err;
        logic       paged;
        logic       we;
        logic [7:0] addr;
        logic [7:0] rdata;
        logic       rvalid;
    } psd_state_t;

    psd_state_t state_reg;
    psd_state_t state_next;
    psd_class_t cls;
    logic       in_space;
    logic       bit_ok;
    logic       is_page_sel;
    logic [7:0] byte_addr;

    // bit operations carry a bit address; the byte holding it is addr[7:3]*8
    assign byte_addr = i_bit_op ? {i_addr[7:3], 3'h0} : i_addr;

    psd_map u_map (
        .i_addr (byte_addr),
        .i_page (state_reg.page),
        .o_class(cls)
    );

    // decode classification for the current access
    always_comb begin
        in_space    = i_direct && (byte_addr >= PSD_SPACE_BASE);
        bit_ok      = ((byte_addr[2:0] & PSD_BIT_LOW_MASK) == PSD_BIT_LOW_HIT);
        is_page_sel = (byte_addr == PSD_PAGE_SEL_ADR);
    end

    // one next-state process; page select is plain storage, all 8 bits kept
    always_comb begin
        state_next        = state_reg;
        state_next.rvalid = 1'b0;
        state_next.we     = 1'b0;
        if (i_req) begin
            state_next.addr     = byte_addr;
            state_next.sfr_sel  = in_space;
            state_next.ram_sel  = !in_space;
            state_next.bit_err  = in_space && i_bit_op && !bit_ok;
            // page register is never paged out, so software can always get back
            state_next.reserved = in_space && !is_page_sel && (cls == PSD_CLS_NONE);
            state_next.paged    = in_space && (cls == PSD_CLS_PAGED);
            state_next.we       = i_write && in_space && !state_next.reserved
                                  && !state_next.bit_err;
            state_next.rvalid   = !i_write;
            state_next.rdata    = PSD_UNDEF_READ;
            if (in_space && is_page_sel) begin
                if (i_write) begin
                    state_next.page = i_wdata;
                end else begin
                    state_next.rdata = state_reg.page;
                end
            end
        end
    end

    // single register stage; synchronous reset to constants only
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg <= '{page: PSD_PAGE_RESET, addr: 8'h00, rdata: 8'h00, default: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_sfr_sel  = state_reg.sfr_sel;
    assign o_ram_sel  = state_reg.ram_sel;
    assign o_reserved = state_reg.reserved;
    assign o_bit_err  = state_reg.bit_err;
    assign o_paged    = state_reg.paged;
    assign o_we       = state_reg.we;
    assign o_addr     = state_reg.addr;
    assign o_page     = state_reg.page;
    assign o_rdata    = state_reg.rdata;
    assign o_rvalid   = state_reg.rvalid;

    property p_space_route;
        @(posedge i_clock) disable iff (i_rst)
        i_req && i_direct && !i_bit_op && i_addr[7] |=> o_sfr_sel && !o_ram_sel;
    endproperty
    a_space_route: assert property (p_space_route) else $error("high direct not routed");

    property p_low_ram;
        @(posedge i_clock) disable iff (i_rst)
        i_req && !i_bit_op && !i_addr[7] |=> o_ram_sel && !o_sfr_sel;
    endproperty
    a_low_ram: assert property (p_low_ram) else $error("low address not to ram");

    property p_bit_ok;
        @(posedge i_clock) disable iff (i_rst)
        i_req && i_direct && i_bit_op && i_addr[7] |=> !o_bit_err;
    endproperty
    a_bit_ok: assert property (p_bit_ok) else $error("bit access rejected");

    property p_byte_only;
        @(posedge i_clock) disable iff (i_rst)
        o_bit_err |-> o_addr[2:0] != 3'h0 && !o_we;
    endproperty
    a_byte_only: assert property (p_byte_only) else $error("bit error misflagged");

    property p_page_write;
        @(posedge i_clock) disable iff (i_rst)
        i_req && i_direct && i_write && !i_bit_op && i_addr == 8'hbf |=> o_page == $past(i_wdata);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page not stored");

    property p_page_read;
        @(posedge i_clock) disable iff (i_rst)
        i_req && i_direct && !i_write && !i_bit_op && i_addr == 8'hbf
            |=> o_rvalid && o_rdata == $past(o_page) && !o_reserved;
    endproperty
    a_page_read: assert property (p_page_read) else $error("page readback wrong");

    property p_page_hold;
        @(posedge i_clock) disable iff (i_rst)
        !(i_req && i_write) |=> $stable(o_page);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page changed unasked");

    property p_reserved_nowrite;
        @(posedge i_clock) disable iff (i_rst)
        o_reserved |-> !o_we && !o_paged;
    endproperty
    a_reserved_nowrite: assert property (p_reserved_nowrite) else $error("reserved wrote");

    property p_other_page;
        @(posedge i_clock) disable iff (i_rst)
        i_req && i_direct && !i_bit_op && i_addr[7] && i_addr != 8'hbf
            && o_page != 8'h00 && o_page != 8'h0f |=> o_reserved;
    endproperty
    a_other_page: assert property (p_other_page) else $error("unimplemented page decoded");

    // reset must land the page on zero and leave no stale pulse behind
    property p_reset_page;
        @(posedge i_clock)
        i_rst |=> o_page == PSD_PAGE_RESET && !o_we && !o_rvalid;
    endproperty
    a_reset_page: assert property (p_reset_page) else $error("page not reset");

    property p_idle_quiet;
        @(posedge i_clock) disable iff (i_rst)
        !i_req |=> !o_we && !o_rvalid;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pulse without access");

    // only the page register has a readable value here; all else reads as undefined
    property p_undef_read;
        @(posedge i_clock) disable iff (i_rst)
        i_req && !i_write && (!i_direct || i_bit_op || i_addr != PSD_PAGE_SEL_ADR)
            |=> o_rdata == PSD_UNDEF_READ;
    endproperty
    a_undef_read: assert property (p_undef_read) else $error("undefined read not zero");

    property p_ram_no_we;
        @(posedge i_clock) disable iff (i_rst)
        o_ram_sel |-> !o_we && !o_sfr_sel;
    endproperty
    a_ram_no_we: assert property (p_ram_no_we) else $error("ram access wrote register");

    property p_common_both;
        @(posedge i_clock) disable iff (i_rst)
        i_req && i_direct && !i_bit_op && i_addr == PSD_SPACE_BASE
            && (o_page == PSD_PAGE_0 || o_page == PSD_PAGE_F) |=> !o_reserved && !o_paged;
    endproperty
    a_common_both: assert property (p_common_both) else $error("common slot paged");

    property p_bit_byte;
        @(posedge i_clock) disable iff (i_rst)
        i_req && i_bit_op |=> o_addr[2:0] == PSD_BIT_LOW_HIT;
    endproperty
    a_bit_byte: assert property (p_bit_byte) else $error("bit op byte not aligned");

    property p_rvalid_read;
        @(posedge i_clock) disable iff (i_rst)
        i_req |=> o_rvalid != $past(i_write);
    endproperty
    a_rvalid_read: assert property (p_rvalid_read) else $error("read pulse wrong");
endmodule // psd_decoder
`default_nettype wire

//--- verilog/psd_map.sv
/*
 * psd_map: combinational occupancy lookup for the special register space.
 * assumes address already known to lie in 0x80..0xff.
 */
`timescale 1ns/1ps
`default_nettype none
module psd_map
    import psd_pkg::*;
(
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_page,
    output var  psd_class_t o_class
);
    logic on_p0;
    logic on_pf;
    // paged slots decode on page 0 and page f alike; page 0 and f share the rest
    always_comb begin
        on_p0 = (i_page == PSD_PAGE_0);
        on_pf = (i_page == PSD_PAGE_F);
        o_class = PSD_CLS_COMMON;
        unique case (i_addr)
            8'h96, 8'h97, 8'hab, 8'had, 8'hd7: o_class = PSD_CLS_NONE;
            8'hb9, 8'he4, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce, 8'hcf,
            8'hc0, 8'hc1, 8'hc2, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95:
                o_class = (on_p0 || on_pf) ? PSD_CLS_PAGED : PSD_CLS_NONE;
            default: o_class = (on_p0 || on_pf) ? PSD_CLS_COMMON : PSD_CLS_NONE;
        endcase
    end
endmodule // psd_map
`default_nettype wire
